/* inc/dps_pkg.sv */
package dps_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SOFT_RESET_ADDR    = 8'h00;
  localparam logic [7:0] WRITE_INDEX_ADDR   = 8'h46;
  localparam logic [7:0] STEP_TARGET_ADDR   = 8'h47;
  localparam logic [7:0] STEP_DATA_ADDR     = 8'h48;
  localparam logic [7:0] LAUNCH_ADDR        = 8'h49;
  localparam logic [7:0] ENABLE_ADDR        = 8'h4a;
  localparam logic [7:0] CURRENT_INDEX_ADDR = 8'h4b;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int          LAUNCH_GO_BIT   = 8;
  localparam int          STATUS_BUSY_BIT = 8;
  localparam int          TGT_WIDTH_LSB   = 12;
  localparam int          TGT_START_LSB   = 8;
  localparam int          DAT_END_BIT     = 14;
  localparam int          DAT_DELAY_LSB   = 8;
  localparam logic [15:0] TGT_FIELD_MASK  = 16'h7fff;
  localparam logic [15:0] DAT_FIELD_MASK  = 16'h4fff;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic       ENABLE_RESET = 1'b1;
  localparam logic [5:0] INDEX_RESET  = 6'h00;
  localparam int         RAM_DEPTH    = 16;
  localparam int         INDEX_W      = 6;
  localparam logic [5:0] ROM_FIRST    = 6'h10;
  localparam logic [7:0] DUMMY_ADDR   = 8'hff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real UNIT_TIME_US  = 62.5;
  localparam int  UNIT_CYCLES   = int'(UNIT_TIME_US * 1000.0 / CLK_PERIOD_NS);
  localparam int  ADD_UNITS     = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       end_of_program_flag;
    logic [3:0] delay;
    logic [7:0] data;
    logic [2:0] width;
    logic [3:0] start;
    logic [7:0] addr;
  } dps_step_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_WAIT} dps_state_t;

  // Builds a step from a field width in bits
  function automatic dps_step_t dps_mk(input logic [7:0] addr, input int bits,
                                       input logic [3:0] start, input logic [7:0] data,
                                       input logic [3:0] delay, input logic last);
    dps_step_t s;
    s.addr  = addr;
    s.width = 3'(bits - 1);
    s.start = start;
    s.data  = data;
    s.delay = delay;
    s.end_of_program_flag = last;
    return s;
  endfunction

  // Power-up program contents, RAM and ROM
  function automatic dps_step_t dps_default_step(input logic [5:0] idx);
    dps_step_t s;
    case (idx)
      6'h00: s = dps_mk(8'h4c, 1, 4'hf, 8'h01, 4'h6, 1'b0);
      6'h01: s = dps_mk(8'h01, 3, 4'h7, 8'h07, 4'h0, 1'b0);
      6'h02: s = dps_mk(8'h60, 5, 4'h1, 8'h11, 4'h0, 1'b0);
      6'h03: s = dps_mk(8'h54, 7, 4'h0, 8'h33, 4'h9, 1'b0);
      6'h04: s = dps_mk(8'hff, 1, 4'h0, 8'h00, 4'h5, 1'b0);
      6'h05, 6'h06: s = dps_mk(8'hff, 1, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h07: s = dps_mk(8'h60, 6, 4'h2, 8'h3b, 4'h0, 1'b1);
      6'h10: s = dps_mk(8'h60, 7, 4'h1, 8'h00, 4'h0, 1'b0);
      6'h11: s = dps_mk(8'h54, 2, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h12: s = dps_mk(8'h01, 2, 4'h8, 8'h00, 4'h0, 1'b0);
      6'h13: s = dps_mk(8'h4c, 1, 4'hf, 8'h00, 4'h0, 1'b0);
      6'h14: s = dps_mk(8'h01, 2, 4'hc, 8'h00, 4'h0, 1'b1);
      default: s = dps_mk(8'hff, 1, 4'h0, 8'h00, 4'h0, 1'b1);
    endcase
    return s;
  endfunction

  // Cycles per step, execution included
  function automatic logic [31:0] dps_step_cycles(input logic [3:0] delay, input int unit);
    return 32'(((32'd1 << delay) + 32'(ADD_UNITS)) * 32'(unit));
  endfunction

endpackage

/* core/dps_step_ram.sv */
`timescale 1ns/10ps
module dps_step_ram #(
  parameter int WIDTH = $bits(dps_pkg::dps_step_t),
  parameter int DEPTH = dps_pkg::RAM_DEPTH
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Host write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_index,
  input  wire logic [WIDTH-1:0]         wr_word,
  // Sequencer read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic      [WIDTH-1:0]         rd_word
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // power-up reload of defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= WIDTH'(dps_pkg::dps_default_step(6'(i)));
      end
    end else if (wr_en) begin
      mem[wr_index] <= wr_word;
    end
  end

  // Registered read
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_word <= '0;
    end else begin
      rd_word <= mem[rd_index];
    end
  end

endmodule

/* core/dps_sequencer.sv */
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - Power-up memory holds headphone start-up and generic shut-down programs.
// - Host may rewrite locations 0 to 15 at any time.
// - RAM contents survive sequencer enable changes and software reset.
// - Every power-up reloads the default start-up contents into RAM.
// - Launch value 0100h at 49h starts at index 0.
// - Launch value 0110h at 49h starts at index 16.
// - Index 0 sets charge pump, bit 15 of 4Ch, delay code 6h.
// - Index 1 writes 07h, 3 bits at bit 7 of 01h.
// - Index 2 writes 11h, 5 bits at bit 1 of 60h.
// - Index 3 writes 33h, 7 bits at bit 0 of 54h, delay 9h.
// - Indices 4 to 6 are dummy FFh writes, delays 5h, 0h, 0h.
// - Index 7 writes 3Bh, 6 bits at bit 2 of 60h, ends.
// - Index 16 clears 7 bits from bit 1 of 60h.
// - Index 17 clears 2 bits at bit 0 of 54h.
// - Index 18 clears 2 bits from bit 8 of 01h.
// - Index 19 clears bit 15 of 4Ch.
// - Index 20 clears 2 bits from bit 12 of 01h, ends.
// - Step lasts 62.5 us times (2 to the delay code plus 8).
// - Only width-plus-one data bits land at the start position.
// - End flag stops the sequencer once its step time is over.
// - Steps aimed at FFh update nothing and only take time.
module dps_sequencer #(
  parameter int UNIT_CYCLES = dps_pkg::UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Masked control register writes
  output logic             ctl_wr_strobe,
  output logic      [7:0]  ctl_addr,
  output logic      [15:0] ctl_wr_mask,
  output logic      [15:0] ctl_wr_data,
  // Status
  output logic             seq_busy
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Field mask from width code and lsb position
  function automatic logic [15:0] field_mask(input logic [2:0] width, input logic [3:0] start);
    logic [15:0] low;
    low = 16'((17'd2 << width) - 17'd1);
    return 16'(low << start);
  endfunction

  // Assembles a RAM word from the two host halves
  function automatic dps_pkg::dps_step_t pack_step(input logic [15:0] tgt, input logic [15:0] dat);
    dps_pkg::dps_step_t s;
    s.addr  = tgt[7:0];
    s.start = tgt[dps_pkg::TGT_START_LSB +: 4];
    s.width = tgt[dps_pkg::TGT_WIDTH_LSB +: 3];
    s.data  = dat[7:0];
    s.delay = dat[dps_pkg::DAT_DELAY_LSB +: 4];
    s.end_of_program_flag = dat[dps_pkg::DAT_END_BIT];
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dps_pkg::dps_state_t state_reg, state_next;
  logic [3:0]          write_index_reg;
  logic [15:0]         tgt_shadow_reg;
  logic [15:0]         dat_shadow_reg;
  logic                enable_reg;
  logic [5:0]          start_index_reg;
  logic [5:0]          cur_index_reg, cur_index_next;
  logic [31:0]         step_cnt_reg, step_cnt_next;
  logic [31:0]         step_total_reg, step_total_next;
  logic                end_flag_reg, end_flag_next;
  dps_pkg::dps_step_t  rom_word_reg;
  logic [27:0]         ram_word;
  dps_pkg::dps_step_t  step_word;
  logic [15:0]         read_value;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wr_soft   = reg_wr && (reg_addr == dps_pkg::SOFT_RESET_ADDR);
  wire wr_index  = reg_wr && (reg_addr == dps_pkg::WRITE_INDEX_ADDR);
  wire wr_tgt    = reg_wr && (reg_addr == dps_pkg::STEP_TARGET_ADDR);
  wire wr_dat    = reg_wr && (reg_addr == dps_pkg::STEP_DATA_ADDR);
  wire wr_launch = reg_wr && (reg_addr == dps_pkg::LAUNCH_ADDR);
  wire wr_enable = reg_wr && (reg_addr == dps_pkg::ENABLE_ADDR);
  wire launch_go = wr_launch && reg_wdata[dps_pkg::LAUNCH_GO_BIT];
  wire stop_req  = wr_soft || (wr_enable && !reg_wdata[0]) || (wr_launch && !launch_go);
  wire start_req = launch_go && enable_reg;
  wire step_done = (step_cnt_reg == step_total_reg - 32'd1);
  wire in_rom    = (cur_index_reg >= dps_pkg::ROM_FIRST);

  // Host RAM write path, 4-bit index cannot reach ROM
  // program RAM any time
  wire                     ram_wr_en   = wr_tgt || wr_dat;
  wire [15:0]              ram_tgt_src = wr_tgt ? reg_wdata : tgt_shadow_reg;
  wire [15:0]              ram_dat_src = wr_dat ? reg_wdata : dat_shadow_reg;
  wire dps_pkg::dps_step_t ram_wr_word = pack_step(ram_tgt_src, ram_dat_src);

  // Step source select
  // ROM from index 16
  assign step_word = in_rom ? rom_word_reg : dps_pkg::dps_step_t'(ram_word);

  // Read mux
  assign read_value =
    (reg_addr == dps_pkg::WRITE_INDEX_ADDR)   ? {12'h000, write_index_reg} :
    (reg_addr == dps_pkg::STEP_TARGET_ADDR)   ? tgt_shadow_reg :
    (reg_addr == dps_pkg::STEP_DATA_ADDR)     ? dat_shadow_reg :
    (reg_addr == dps_pkg::LAUNCH_ADDR)        ? {7'h00, seq_busy, 2'h0, start_index_reg} :
    (reg_addr == dps_pkg::ENABLE_ADDR)        ? {15'h0000, enable_reg} :
    (reg_addr == dps_pkg::CURRENT_INDEX_ADDR) ? {7'h00, seq_busy, 2'h0, cur_index_reg} :
    16'h0000;

  // ----------------------------------------------------------------
  // Step memory
  // ----------------------------------------------------------------
  // defaults live in RAM and ROM
  dps_step_ram #(
    .WIDTH (28),
    .DEPTH (dps_pkg::RAM_DEPTH)
  ) u_ram (
    .clk      (clk),
    .rst      (rst),
    .wr_en    (ram_wr_en),
    .wr_index (write_index_reg),
    .wr_word  (ram_wr_word),
    .rd_index (cur_index_reg[3:0]),
    .rd_word  (ram_word)
  );

  // Constant ROM, registered to match RAM latency
  always_ff @(posedge clk) begin
    if (rst) begin
      rom_word_reg <= '0;
    end else begin
      rom_word_reg <= dps_pkg::dps_default_step(cur_index_reg);
    end
  end

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  // soft reset returns registers to reset values (enable to 1), not RAM
  always_ff @(posedge clk) begin
    if (rst || wr_soft) begin
      write_index_reg <= '0;
      tgt_shadow_reg  <= '0;
      dat_shadow_reg  <= '0;
      enable_reg      <= dps_pkg::ENABLE_RESET;
      start_index_reg <= dps_pkg::INDEX_RESET;
    end else begin
      if (wr_index)  write_index_reg <= reg_wdata[3:0];
      if (wr_tgt)    tgt_shadow_reg  <= reg_wdata & dps_pkg::TGT_FIELD_MASK;
      if (wr_dat)    dat_shadow_reg  <= reg_wdata & dps_pkg::DAT_FIELD_MASK;
      if (wr_enable) enable_reg      <= reg_wdata[0];
      if (wr_launch) start_index_reg <= reg_wdata[5:0];
    end
  end

  // Read data, valid one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? read_value : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer engine
  // ----------------------------------------------------------------
  // Next state
  always_comb begin
    state_next      = state_reg;
    cur_index_next  = cur_index_reg;
    step_cnt_next   = step_cnt_reg + 32'd1;
    step_total_next = step_total_reg;
    end_flag_next   = end_flag_reg;
    case (state_reg)
      dps_pkg::ST_IDLE: begin
        step_cnt_next = '0;
      end
      dps_pkg::ST_FETCH: begin
        state_next = dps_pkg::ST_EXEC;
      end
      dps_pkg::ST_EXEC: begin
        state_next      = dps_pkg::ST_WAIT;
        step_total_next = dps_pkg::dps_step_cycles(step_word.delay, UNIT_CYCLES);
        end_flag_next   = step_word.end_of_program_flag;
      end
      dps_pkg::ST_WAIT: begin
        if (step_done) begin
          step_cnt_next = '0;
          if (end_flag_reg) begin
            state_next = dps_pkg::ST_IDLE;
          end else begin
            state_next     = dps_pkg::ST_FETCH;
            cur_index_next = cur_index_reg + 6'd1;
          end
        end
      end
      default: begin
        state_next = dps_pkg::ST_IDLE;
      end
    endcase
    if (stop_req) begin
      state_next    = dps_pkg::ST_IDLE;
      step_cnt_next = '0;
      if (wr_soft) cur_index_next = dps_pkg::INDEX_RESET;
    end else if (start_req) begin
      state_next     = dps_pkg::ST_FETCH;
      cur_index_next = reg_wdata[5:0];
      step_cnt_next  = '0;
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg      <= dps_pkg::ST_IDLE;
      cur_index_reg  <= dps_pkg::INDEX_RESET;
      step_cnt_reg   <= '0;
      step_total_reg <= '0;
      end_flag_reg   <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cur_index_reg  <= cur_index_next;
      step_cnt_reg   <= step_cnt_next;
      step_total_reg <= step_total_next;
      end_flag_reg   <= end_flag_next;
    end
  end

  // ----------------------------------------------------------------
  // Control write port
  // ----------------------------------------------------------------
  // dummy target writes nothing
  wire exec_write = (state_reg == dps_pkg::ST_EXEC) && (state_next == dps_pkg::ST_WAIT) &&
                    (step_word.addr != dps_pkg::DUMMY_ADDR);
  wire [15:0] exec_mask = field_mask(step_word.width, step_word.start);
  // only the field bits are written
  wire [15:0] exec_data = 16'({8'h00, step_word.data} << step_word.start) & exec_mask;

  // Output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_wr_strobe <= 1'b0;
      ctl_addr      <= '0;
      ctl_wr_mask   <= '0;
      ctl_wr_data   <= '0;
      seq_busy      <= 1'b0;
    end else begin
      ctl_wr_strobe <= exec_write;
      if (exec_write) begin
        ctl_addr    <= step_word.addr;
        ctl_wr_mask <= exec_mask;
        ctl_wr_data <= exec_data;
      end
      seq_busy <= (state_next != dps_pkg::ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_LAUNCH_INDEX: assert property (@(posedge clk) disable iff (rst)
    (start_req && !stop_req) |=> (state_reg == dps_pkg::ST_FETCH) &&
      (cur_index_reg == $past(reg_wdata[5:0])) ##2 (state_reg == dps_pkg::ST_WAIT))
    else $error("launch did not start at the written index");

  AST_FIELD_ONLY: assert property (@(posedge clk) disable iff (rst)
    ctl_wr_strobe |-> ((ctl_wr_data & ~ctl_wr_mask) == 16'h0000) && (ctl_wr_mask != 16'h0000))
    else $error("control write touches bits outside its field");

  AST_DUMMY_SILENT: assert property (@(posedge clk) disable iff (rst)
    ((state_reg == dps_pkg::ST_EXEC) && (step_word.addr == dps_pkg::DUMMY_ADDR)) |=>
      !ctl_wr_strobe)
    else $error("dummy step produced a control write");

  AST_STEP_TOTAL: assert property (@(posedge clk) disable iff (rst)
    ((state_reg == dps_pkg::ST_EXEC) && !stop_req && !start_req) |=>
      (step_total_reg == dps_pkg::dps_step_cycles($past(step_word.delay), UNIT_CYCLES)) &&
      (step_cnt_reg == 32'd2))
    else $error("step time does not match its delay code");

  AST_NOT_EARLY: assert property (@(posedge clk) disable iff (rst)
    ((state_reg == dps_pkg::ST_WAIT) && !step_done && !stop_req && !start_req) |=>
      (state_reg == dps_pkg::ST_WAIT) && (step_cnt_reg == $past(step_cnt_reg) + 32'd1))
    else $error("step left before its time elapsed");

  AST_END_STOP: assert property (@(posedge clk) disable iff (rst)
    ((state_reg == dps_pkg::ST_WAIT) && step_done && end_flag_reg && !start_req) |=>
      (state_reg == dps_pkg::ST_IDLE) && !seq_busy)
    else $error("sequencer did not stop at end of program");

  AST_ADVANCE: assert property (@(posedge clk) disable iff (rst)
    ((state_reg == dps_pkg::ST_WAIT) && step_done && !end_flag_reg && !stop_req && !start_req) |=>
      (state_reg == dps_pkg::ST_FETCH) && (cur_index_reg == $past(cur_index_reg) + 6'd1))
    else $error("sequencer did not advance to next index");

  AST_ROM_CONST: assert property (@(posedge clk) disable iff (rst)
    ((state_reg == dps_pkg::ST_EXEC) && in_rom) |->
      (step_word == dps_pkg::dps_default_step(cur_index_reg)))
    else $error("ROM step differs from its constant contents");

  AST_SOFT_STOP: assert property (@(posedge clk) disable iff (rst)
    wr_soft |=> (state_reg == dps_pkg::ST_IDLE) && !ctl_wr_strobe && enable_reg)
    else $error("software reset did not stop the sequencer");

  COV_STARTUP: cover property (@(posedge clk) disable iff (rst)
    start_req && (reg_wdata[5:0] == 6'h00));
  COV_SHUTDOWN: cover property (@(posedge clk) disable iff (rst)
    start_req && (reg_wdata[5:0] == dps_pkg::ROM_FIRST));
  COV_DUMMY: cover property (@(posedge clk) disable iff (rst)
    (state_reg == dps_pkg::ST_EXEC) && (step_word.addr == dps_pkg::DUMMY_ADDR));
  COV_END: cover property (@(posedge clk) disable iff (rst)
    (state_reg == dps_pkg::ST_WAIT) && step_done && end_flag_reg);

endmodule

/* test/dps_ctl_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Control register bank behind the masked write port
// ----------------------------------------------------------------
module dps_ctl_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Masked write port
  input  wire logic        ctl_wr_strobe,
  input  wire logic [7:0]  ctl_addr,
  input  wire logic [15:0] ctl_wr_mask,
  input  wire logic [15:0] ctl_wr_data
);
  logic [15:0] mem [256];

  always_ff @(posedge clk) begin
    if (rst) begin
      mem <= '{default: 16'h0000};
    end else if (ctl_wr_strobe && ctl_addr != 8'hff) begin
      mem[ctl_addr] <= (mem[ctl_addr] & ~ctl_wr_mask) | (ctl_wr_data & ctl_wr_mask);
    end
  end
endmodule

/* test/default_power_sequence_rom_bench.sv */
`timescale 1ns/10ps
module default_power_sequence_rom_bench;
  localparam int U = 2;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        ctl_wr_strobe;
  logic [7:0]  ctl_addr;
  logic [15:0] ctl_wr_mask;
  logic [15:0] ctl_wr_data;
  logic        seq_busy;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          busy_cnt = 0;
  logic [39:0] sq [$];
  int          st [$];
  logic [39:0] eq [$];
  int          gq [$];

  // Clock
  always #2.5 clk = ~clk;

  dps_sequencer #(.UNIT_CYCLES(U)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ctl_wr_strobe(ctl_wr_strobe), .ctl_addr(ctl_addr), .ctl_wr_mask(ctl_wr_mask),
    .ctl_wr_data(ctl_wr_data), .seq_busy(seq_busy));
  dps_ctl_model ctl_regs (.clk(clk), .rst(rst), .ctl_wr_strobe(ctl_wr_strobe),
    .ctl_addr(ctl_addr), .ctl_wr_mask(ctl_wr_mask), .ctl_wr_data(ctl_wr_data));

  // Strobe and busy recorder
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (seq_busy === 1'b1) busy_cnt <= busy_cnt + 1;
    if (ctl_wr_strobe === 1'b1) begin
      sq.push_back({ctl_addr, ctl_wr_mask, ctl_wr_data});
      st.push_back(cyc);
    end
  end

  // Step time in cycles
  function automatic int tc(input int d);
    return ((1 << d) + 8) * U;
  endfunction

  // Expected address, mask and data of one step
  function automatic logic [39:0] ew(input logic [7:0] a, input int b, input int l,
                                     input logic [7:0] d);
    logic [15:0] m;
    m = 16'(((32'd1 << b) - 1) << l);
    return {a, m, (16'(d) << l) & m};
  endfunction

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Launch, wait for the end, compare strobes, spacing and busy time
  task automatic run(input logic [15:0] go, input int bx);
    sq.delete();
    st.delete();
    busy_cnt = 0;
    wr(dps_pkg::LAUNCH_ADDR, go);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5000 && seq_busy === 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(seq_busy, 40'h0);
    chk(sq.size(), eq.size());
    foreach (eq[i]) if (i < sq.size()) chk(sq[i], eq[i]);
    foreach (gq[i]) if (i + 1 < st.size()) chk(st[i + 1] - st[i], gq[i]);
    chk(busy_cnt, bx);
    $display("test launch %h done", go);
  endtask

  task automatic exp_startup;
    eq = '{ew(8'h4c, 1, 15, 8'h01), ew(8'h01, 3, 7, 8'h07), ew(8'h60, 5, 1, 8'h11),
           ew(8'h54, 7, 0, 8'h33), ew(8'h60, 6, 2, 8'h3b)};
    gq = '{tc(6), tc(0), tc(0), tc(9) + tc(5) + 2 * tc(0)};
  endtask

  task automatic exp_shutdown;
    eq = '{ew(8'h60, 7, 1, 8'h00), ew(8'h54, 2, 0, 8'h00), ew(8'h01, 2, 8, 8'h00),
           ew(8'h4c, 1, 15, 8'h00), ew(8'h01, 2, 12, 8'h00)};
    gq = '{tc(0), tc(0), tc(0), tc(0)};
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [15:0] r;
    logic [39:0] keep;
    logic [7:0]  a, d;
    int          w, l, dl;
    void'($urandom(32'h88863a2c));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(dps_pkg::ENABLE_ADDR, r);
    chk(r, 16'h0001);
    rd(8'h10, r);
    chk(r, 16'h0000);
    // host path and bias assumed set
    exp_startup();
    run(16'h0100, tc(6) + tc(9) + tc(5) + 5 * tc(0));
    chk(ctl_regs.mem[8'h60], 16'h00ee);
    rd(dps_pkg::CURRENT_INDEX_ADDR, r);
    chk(r, 16'h0007);
    exp_shutdown();
    run(16'h0110, 5 * tc(0));
    // abort by clearing the launch bit
    sq.delete();
    busy_cnt = 0;
    wr(dps_pkg::LAUNCH_ADDR, 16'h0100);
    repeat (20) @(posedge clk);
    wr(dps_pkg::LAUNCH_ADDR, 16'h0000);
    repeat (200) @(posedge clk);
    chk(sq.size(), 1);
    chk(sq[0], ew(8'h4c, 1, 15, 8'h01));
    chk(busy_cnt, 22);
    $display("test launch abort done");
    for (int k = 0; k < 5; k++) begin
      a = 8'($urandom_range(254));
      w = $urandom_range(7);
      l = (k == 0) ? 15 : $urandom_range(15);
      d = 8'($urandom);
      dl = $urandom_range(3);
      wr(dps_pkg::WRITE_INDEX_ADDR, 16'h0000);
      wr(dps_pkg::STEP_TARGET_ADDR, {1'b0, 3'(w), 4'(l), a});
      wr(dps_pkg::STEP_DATA_ADDR, {2'b01, 2'b00, 4'(dl), d});
      eq = '{ew(a, w + 1, l, d)};
      gq = {};
      run(16'h0100, tc(dl));
    end
    keep = eq[0];
    wr(dps_pkg::ENABLE_ADDR, 16'h0000);
    eq = {};
    run(16'h0100, 0);
    wr(dps_pkg::ENABLE_ADDR, 16'h0001);
    wr(dps_pkg::SOFT_RESET_ADDR, 16'h0000);
    eq = '{keep};
    run(16'h0100, tc(dl));
    wr(dps_pkg::WRITE_INDEX_ADDR, 16'h0010);
    wr(dps_pkg::STEP_TARGET_ADDR, 16'h0001);
    wr(dps_pkg::STEP_DATA_ADDR, 16'h4000);
    exp_shutdown();
    run(16'h0110, 5 * tc(0));
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    exp_startup();
    run(16'h0100, tc(6) + tc(9) + tc(5) + 5 * tc(0));
    print_verdict();
  end

  // Watchdog
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule
